/* dv/lcdcd_core_tb.sv */
// testbench of the command decoder: wishbone tasks plus a pin host model
// assumes a shortened clear time and 1600-cycle command busy time
`timescale 1ns/1ps

module lcdcd_core_tb;
    localparam int CLR = 20;                  // shortened clear busy time
    logic                    clock = 1'b0;    // 40 MHz clock
    logic                    srst = 1'b1;     // synchronous reset
    lcdcd_pkg::lcdcd_wbreq_t wbReq = '0;      // bus request
    lcdcd_pkg::lcdcd_wbrsp_t wbRsp;           // bus answer
    lcdcd_pkg::lcdcd_pins_t  pins;            // nibble pins
    logic [6:0]              scanAddr = 7'h00;
    logic [7:0]              scanChar;
    lcdcd_pkg::lcdcd_view_t  view;
    int                      errCount = 0;
    int                      numChecks = 0;
    logic [31:0]             rd;              // last read data
    logic [7:0]              dc [4] = '{8'h08, 8'h0C, 8'h0E, 8'h0F};

    // clock generator
    always #12.5 clock = ~clock;

    lcdcd_core #(.CLR_CYCLES(CLR)) lcdcd_core_i (
        .clock(clock), .srst(srst), .wbReq(wbReq), .wbRsp(wbRsp),
        .pins(pins), .scanAddr(scanAddr), .scanChar(scanChar),
        .view(view));
    lcdcd_host_model lcdcd_host_model_i (.clock(clock), .pins(pins));

    // verdict and end of run
    task automatic complete_run();
        if (errCount == 0 && numChecks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    // compare one value
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        numChecks++;
        if (got !== exp) begin
            errCount++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // classic single wishbone cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [3:0] adr,
                      input logic [7:0] dat, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clock);
        wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1,
                   dat: {24'h0, dat}};
        do begin
            @(posedge clock);
            n++;
        end while (wbRsp.ack !== 1'b1 && n < 50);
        q = wbRsp.dat;
        wbReq <= '0;
        if (n >= 50) chk("ack", 32'h1, 32'h0);
    endtask : wb

    // poll the busy bit until the decoder is free
    task automatic idle();
        int n;
        n = 0;
        do begin
            wb(1'b0, 4'h0, 8'h00, rd);
            n++;
        end while (rd[7] !== 1'b0 && n < 2000);
        chk("busy", 32'h0, {31'h0, rd[7]});
    endtask : idle

    // write a command and wait for it
    task automatic cmd(input logic [7:0] c);
        wb(1'b1, 4'h0, c, rd);
        idle();
    endtask : cmd

    // write a data byte and wait for it
    task automatic dat(input logic [7:0] b);
        wb(1'b1, 4'h4, b, rd);
        idle();
    endtask : dat

    // read a location and compare
    task automatic rdc(input logic [3:0] a, input string w,
                       input logic [31:0] e);
        wb(1'b0, a, 8'h00, rd);
        chk(w, e, rd);
    endtask : rdc

    // watchdog well beyond the expected run length
    initial begin
        #2000000;
        errCount++;
        complete_run();
    end

    // main sequence
    initial begin
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        rdc(4'h8, "flags rst", 32'h10);
        rdc(4'h0, "cmd rst", 32'h0);
        rdc(4'hC, "unmapped", 32'h0);
        rdc(4'h4, "datread", 32'h0);
        cmd(8'h3C);
        wb(1'b0, 4'h8, 8'h00, rd);
        chk("func", 32'h7, {29'h0, rd[15:13]});
        for (int c = 4; c < 8; c++) begin
            cmd(8'(c));
            wb(1'b0, 4'h8, 8'h00, rd);
            chk("entry", 32'(c & 3), {30'h0, rd[4:3]});
        end
        foreach (dc[i]) begin
            cmd(dc[i]);
            wb(1'b0, 4'h8, 8'h00, rd);
            chk("disp", {29'h0, dc[i][2:0]}, {29'h0, rd[2:0]});
        end
        chk("view", 32'h7,
            {29'h0, view.dispOn, view.cursorOn, view.blinkOn});
        // second byte while busy is dropped
        wb(1'b1, 4'h0, 8'h0D, rd);
        wb(1'b1, 4'h0, 8'h08, rd);
        idle();
        rdc(4'h8, "refused", 32'hE01D);
        cmd(8'h06);
        wb(1'b1, 4'h0, 8'hA5, rd);
        rdc(4'h0, "busy addr", 32'hA5);
        idle();
        rdc(4'h0, "ddaddr", 32'h25);
        chk("cursor", 32'h25, {25'h0, view.cursorAddr});
        dat(8'h41);
        scanAddr <= 7'h25;
        rdc(4'h0, "inc", 32'h26);
        chk("char", 32'h41, {24'h0, scanChar});
        cmd(8'h10);
        rdc(4'h0, "left", 32'h25);
        cmd(8'h14);
        rdc(4'h0, "right", 32'h26);
        cmd(8'h18);
        wb(1'b0, 4'h8, 8'h00, rd);
        chk("dleft", 32'h1, {25'h0, rd[12:6]});
        cmd(8'h1C);
        wb(1'b0, 4'h8, 8'h00, rd);
        chk("dright", 32'h0, {25'h0, rd[12:6]});
        chk("kept", 32'h41, {24'h0, scanChar});
        cmd(8'h04);
        dat(8'h42);
        rdc(4'h0, "dec", 32'h25);
        cmd(8'h07);
        dat(8'h43);
        wb(1'b0, 4'h8, 8'h00, rd);
        chk("dshift", 32'h1, {25'h0, rd[12:6]});
        chk("voffs", 32'h1, {25'h0, view.shiftOffset});
        cmd(8'h6A);
        rdc(4'h0, "cgaddr", 32'h2A);
        wb(1'b0, 4'h8, 8'h00, rd);
        chk("cgsel", 32'h1, {31'h0, rd[5]});
        dat(8'h55);
        rdc(4'h0, "cginc", 32'h2B);
        chk("ddkept", 32'h43, {24'h0, scanChar});
        cmd(8'h85);
        dat(8'h44);
        scanAddr <= 7'h05;
        wb(1'b1, 4'h0, 8'h02, rd);
        rdc(4'h0, "homebusy", 32'h80);
        idle();
        rdc(4'h0, "home", 32'h0);
        chk("homekeep", 32'h44, {24'h0, scanChar});
        cmd(8'h04);
        cmd(8'h01);
        rdc(4'h0, "clear", 32'h0);
        chk("blank", 32'h20, {24'h0, scanChar});
        wb(1'b0, 4'h8, 8'h00, rd);
        chk("clrflags", 32'h1, {24'h0, rd[12:6], rd[4]});
        lcdcd_host_model_i.send_byte(8'h90, 1'b0);
        idle();
        lcdcd_host_model_i.send_byte(8'h5A, 1'b1);
        idle();
        scanAddr <= 7'h10;
        rdc(4'h0, "pinaddr", 32'h11);
        chk("pinchar", 32'h5A, {24'h0, scanChar});
        complete_run();
    end
endmodule : lcdcd_core_tb

/* dv/lcdcd_host_model.sv */
// host model: feeds bytes to the nibble pins as the shift register would
// assumes the decoder samples the pins on the next rising clock edge
`timescale 1ns/1ps

module lcdcd_host_model (
    input  wire logic                   clock,
    output      lcdcd_pkg::lcdcd_pins_t pins
);
    // lines idle low before the first frame
    initial pins = '0;

    // one shift register transfer, changed just after a clock edge
    task automatic xfer(input logic [3:0] nib, input logic sel,
                        input logic stb);
        @(posedge clock);
        pins <= '{nibble: nib, registerSelectLine: sel, strobe: stb};
    endtask : xfer

    // byte as two nibbles, three transfers each
    task automatic send_byte(input logic [7:0] b, input logic isData);
        logic [3:0] n;
        n = 4'h0;
        for (int k = 1; k >= 0; k--) begin
            n = b[k*4 +: 4];
            xfer(n, isData, 1'b0);
            xfer(n, isData, 1'b1);
            xfer(n, isData, 1'b0);
        end
        // stale data is not left on the lines after the frame
        xfer(~n, ~isData, 1'b0);
    endtask : send_byte
endmodule : lcdcd_host_model

/* hw/lcdcd_core.sv */
// character display command decoder: wishbone registers and nibble pins
// feed one byte decoder that keeps display memory and settings
// assumes one 40 MHz clock, synchronous pins and a classic wishbone master
`timescale 1ns/1ps
`include "lcdcd_params.svh"

module lcdcd_core #(
    parameter int CLR_CYCLES = `LCDCD_CLR_CYCLES
) (
    input  wire logic                clock,
    input  wire logic                srst,
    input  wire lcdcd_pkg::lcdcd_wbreq_t wbReq,
    output      lcdcd_pkg::lcdcd_wbrsp_t wbRsp,
    input  wire lcdcd_pkg::lcdcd_pins_t  pins,
    input  wire logic [6:0]          scanAddr,
    output      logic [7:0]          scanChar,
    output      lcdcd_pkg::lcdcd_view_t  view
);

    lcdcd_pkg::lcdcd_state_t s_q;        // registered state
    lcdcd_pkg::lcdcd_state_t s_d;        // next state

    logic       wbFire;                  // write taken at the ack edge
    logic       wbCmdWr;                 // write to the command location
    logic       wbDatWr;                 // write to the data location
    logic       strobeFall;              // falling edge of the pin strobe
    logic       pinByteDone;             // second nibble latched
    logic       execValid;               // a byte is offered
    logic       execIsData;              // offered byte is data
    logic [7:0] execByte;                // offered byte
    logic       busy;                    // execution still running
    logic       accCmd;                  // command accepted this cycle
    logic       accData;                 // data accepted this cycle
    logic [6:0] curAddr;                 // address shown on a command read

    // byte sources, bus before pins
    assign wbFire      = wbReq.cyc & wbReq.stb & wbReq.we & s_q.ack
                         & wbReq.sel[0];
    assign wbCmdWr     = wbFire & (wbReq.adr == `LCDCD_OFS_CMD);
    assign wbDatWr     = wbFire & (wbReq.adr == `LCDCD_OFS_DATA);
    // R12 nibble and select
    assign strobeFall  = s_q.prevStrobe & ~pins.strobe;
    // R13 strobe edge latch
    assign pinByteDone = strobeFall & s_q.nibPhase;
    assign execValid   = wbCmdWr | wbDatWr | pinByteDone;
    assign execIsData  = (wbCmdWr | wbDatWr) ? wbDatWr
                                             : pins.registerSelectLine;
    assign execByte    = (wbCmdWr | wbDatWr) ? wbReq.dat[7:0]
                                             : {s_q.hiNib, pins.nibble};
    assign busy        = (s_q.busyCnt != '0);
    assign accCmd      = execValid & ~busy & ~execIsData;
    assign accData     = execValid & ~busy & execIsData;
    assign curAddr     = s_q.selCg ? {1'b0, s_q.cgAddr} : s_q.ddAddr;

    // outputs straight from state flip-flops
    // each output struct has one driver, members are not driven apart
    assign wbRsp    = '{ack: s_q.ack, dat: s_q.rdat};
    assign scanChar = s_q.scanChar;
    assign view     = '{dispOn:      s_q.dispOn,
                        cursorOn:    s_q.cursorOn,
                        blinkOn:     s_q.blinkOn,
                        cursorAddr:  s_q.ddAddr,
                        shiftOffset: s_q.shiftOffset};

    // next state: bus slave, nibble pairing, busy timer, decoder
    always_comb begin
        s_d = s_q;
        // ack one cycle after the request, dropped the cycle after
        s_d.ack = wbReq.cyc & wbReq.stb & ~s_q.ack;
        s_d.rdat = '0;
        if (wbReq.cyc && wbReq.stb && !s_q.ack && !wbReq.we) begin
            if (wbReq.adr == `LCDCD_OFS_CMD) begin
                // R03 busy and address
                s_d.rdat = 32'({busy, curAddr});
            end else if (wbReq.adr == `LCDCD_OFS_FLAGS) begin
                // settings snapshot
                s_d.rdat = 32'({s_q.func, s_q.shiftOffset, s_q.selCg,
                                s_q.incr, s_q.shiftEn, s_q.dispOn,
                                s_q.cursorOn, s_q.blinkOn});
            end
        end
        // glyph scan port
        s_d.scanChar = s_q.ddram[scanAddr];
        // nibble pairing, high nibble first
        s_d.prevStrobe = pins.strobe;
        if (strobeFall) begin
            s_d.nibPhase = ~s_q.nibPhase;
            if (!s_q.nibPhase) begin
                s_d.hiNib = pins.nibble;
            end
        end
        // busy timer counts down
        if (busy) begin
            s_d.busyCnt = s_q.busyCnt - 1'b1;
        end
        if (accData) begin
            s_d.busyCnt = lcdcd_pkg::lcdcd_busy_t'(`LCDCD_CMD_CYCLES);
            if (s_q.selCg) begin
                // glyph pattern byte
                s_d.cgram[s_q.cgAddr] = execByte;
                s_d.cgAddr = s_q.incr ? s_q.cgAddr + 6'h01
                                      : s_q.cgAddr - 6'h01;
            end else begin
                // R11 character stored
                s_d.ddram[s_q.ddAddr] = execByte;
                // R14 step and shift
                s_d.ddAddr = s_q.incr ? s_q.ddAddr + 7'h01
                                      : s_q.ddAddr - 7'h01;
                if (s_q.shiftEn) begin
                    s_d.shiftOffset = s_q.incr ? s_q.shiftOffset + 7'h01
                                               : s_q.shiftOffset - 7'h01;
                end
            end
        end else if (accCmd) begin
            s_d.busyCnt = lcdcd_pkg::lcdcd_busy_t'(`LCDCD_CMD_CYCLES);
            if (execByte >= `LCDCD_CODE_DDADDR) begin
                // R10 display address
                s_d.ddAddr = execByte[6:0];
                s_d.selCg  = 1'b0;
            end else if (execByte >= `LCDCD_CODE_CGADDR) begin
                // R09 glyph address
                s_d.cgAddr = execByte[5:0];
                s_d.selCg  = 1'b1;
            end else if (execByte >= `LCDCD_CODE_FUNC) begin
                // R08 function set
                s_d.func = execByte[4:2];
            end else if (execByte >= `LCDCD_CODE_SHIFT) begin
                // R07 nondestructive move
                if (execByte[`LCDCD_SH_DISP]) begin
                    s_d.shiftOffset = execByte[`LCDCD_SH_RIGHT]
                                      ? s_q.shiftOffset - 7'h01
                                      : s_q.shiftOffset + 7'h01;
                end else begin
                    s_d.ddAddr = execByte[`LCDCD_SH_RIGHT]
                                 ? s_q.ddAddr + 7'h01
                                 : s_q.ddAddr - 7'h01;
                end
            end else if (execByte >= `LCDCD_CODE_DISP) begin
                // R06 display control
                s_d.dispOn   = execByte[`LCDCD_DC_DISP];
                s_d.cursorOn = execByte[`LCDCD_DC_CUR];
                s_d.blinkOn  = execByte[`LCDCD_DC_BLINK];
            end else if (execByte >= `LCDCD_CODE_ENTRY) begin
                // R05 entry mode
                s_d.incr    = execByte[`LCDCD_ENT_INC];
                s_d.shiftEn = execByte[`LCDCD_ENT_SHIFT];
            end else if (execByte >= `LCDCD_CODE_HOME) begin
                // R04 cursor home
                s_d.busyCnt     = lcdcd_pkg::lcdcd_busy_t'(CLR_CYCLES);
                s_d.ddAddr      = '0;
                s_d.selCg       = 1'b0;
                s_d.shiftOffset = '0;
            end else if (execByte == `LCDCD_CODE_CLEAR) begin
                // R04 clear and home
                s_d.busyCnt     = lcdcd_pkg::lcdcd_busy_t'(CLR_CYCLES);
                for (int i = 0; i < `LCDCD_DD_DEPTH; i++) begin
                    s_d.ddram[i] = `LCDCD_BLANK;
                end
                s_d.ddAddr      = '0;
                s_d.selCg       = 1'b0;
                s_d.shiftOffset = '0;
                s_d.incr        = 1'b1;
            end
        end
    end

    // state register; increment mode after reset
    always_ff @(posedge clock) begin
        if (srst) begin
            s_q      <= '0;
            s_q.incr <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    // command read returns busy and address
    property p_statusRead;
        wbRsp.ack && !$past(wbReq.we) && $past(wbReq.adr) == `LCDCD_OFS_CMD
        |-> wbRsp.dat[6:0] == $past(curAddr)
            && wbRsp.dat[`LCDCD_BUSY_BIT] == $past(busy);
    endproperty
    a_statusRead: assert property (p_statusRead) // R03
        else $error("command read does not show busy and address");

    // clear blanks memory, homes, and stays busy the long time
    property p_clear;
        accCmd && execByte == `LCDCD_CODE_CLEAR
        |=> s_q.ddAddr == 7'h00 && s_q.ddram[0] == `LCDCD_BLANK
            && s_q.busyCnt == lcdcd_pkg::lcdcd_busy_t'(CLR_CYCLES)
            ##1 busy;
    endproperty
    a_clear: assert property (p_clear) // R04
        else $error("clear did not blank, home or go busy");

    // home keeps memory
    property p_home;
        accCmd && execByte == `LCDCD_CODE_HOME
        |=> s_q.ddAddr == 7'h00 && $stable(s_q.ddram) && busy;
    endproperty
    a_home: assert property (p_home) // R04
        else $error("home changed memory or address");

    // entry mode bits taken, short delay
    property p_entry;
        accCmd && execByte >= `LCDCD_CODE_ENTRY
        && execByte < `LCDCD_CODE_DISP
        |=> s_q.incr == $past(execByte[`LCDCD_ENT_INC])
            && s_q.shiftEn == $past(execByte[`LCDCD_ENT_SHIFT])
            && s_q.busyCnt == lcdcd_pkg::lcdcd_busy_t'(`LCDCD_CMD_CYCLES);
    endproperty
    a_entry: assert property (p_entry) // R05
        else $error("entry mode not applied");

    // display control bits reach the view port
    property p_dispCtl;
        accCmd && execByte >= `LCDCD_CODE_DISP
        && execByte < `LCDCD_CODE_SHIFT
        |=> view.dispOn == $past(execByte[`LCDCD_DC_DISP])
            && view.cursorOn == $past(execByte[`LCDCD_DC_CUR])
            && view.blinkOn == $past(execByte[`LCDCD_DC_BLINK]);
    endproperty
    a_dispCtl: assert property (p_dispCtl) // R06
        else $error("display control not applied");

    // cursor right moves by one and keeps memory
    property p_cursorRight;
        accCmd && execByte == (`LCDCD_CODE_SHIFT | 8'h04)
        |=> s_q.ddAddr == $past(s_q.ddAddr) + 7'h01 && $stable(s_q.ddram);
    endproperty
    a_cursorRight: assert property (p_cursorRight) // R07
        else $error("cursor right move wrong");

    // default function set stored
    property p_func;
        accCmd && execByte == `LCDCD_CODE_FUNCDEF
        |=> s_q.func == 3'h7 ##1 busy;
    endproperty
    a_func: assert property (p_func) // R08
        else $error("function set not stored");

    // glyph address load
    property p_cgAddr;
        accCmd && execByte >= `LCDCD_CODE_CGADDR
        && execByte < `LCDCD_CODE_DDADDR
        |=> s_q.selCg && s_q.cgAddr == $past(execByte[5:0]);
    endproperty
    a_cgAddr: assert property (p_cgAddr) // R09
        else $error("glyph address not loaded");

    // display address load places cursor
    property p_ddAddr;
        accCmd && execByte >= `LCDCD_CODE_DDADDR
        |=> !s_q.selCg && view.cursorAddr == $past(execByte[6:0]);
    endproperty
    a_ddAddr: assert property (p_ddAddr) // R10
        else $error("display address not loaded");

    // data byte stored at the cursor, cursor steps
    property p_dataWrite;
        accData && !s_q.selCg
        |=> s_q.ddram[$past(s_q.ddAddr)] == $past(execByte)
            && s_q.ddAddr == ($past(s_q.incr) ? $past(s_q.ddAddr) + 7'h01
                                              : $past(s_q.ddAddr) - 7'h01);
    endproperty
    a_dataWrite: assert property (p_dataWrite) // R11 R14
        else $error("data write not stored or cursor not stepped");

    // data write with shifting on moves the window with the cursor
    property p_dataShift;
        accData && !s_q.selCg && s_q.shiftEn
        |=> s_q.shiftOffset == ($past(s_q.incr)
                                ? $past(s_q.shiftOffset) + 7'h01
                                : $past(s_q.shiftOffset) - 7'h01);
    endproperty
    a_dataShift: assert property (p_dataShift) // R14
        else $error("data write did not shift the display window");

    // glyph pattern byte lands at the glyph address, which then steps
    property p_cgWrite;
        accData && s_q.selCg
        |=> s_q.cgram[$past(s_q.cgAddr)] == $past(execByte)
            && s_q.cgAddr == ($past(s_q.incr) ? $past(s_q.cgAddr) + 6'h01
                                              : $past(s_q.cgAddr) - 6'h01);
    endproperty
    a_cgWrite: assert property (p_cgWrite) // R09
        else $error("glyph byte not stored or glyph address not stepped");

    // display shift moves only the window, never cursor or memory
    property p_dispShift;
        accCmd && execByte >= (`LCDCD_CODE_SHIFT | 8'h08)
        && execByte < `LCDCD_CODE_FUNC
        |=> $stable(s_q.ddAddr) && $stable(s_q.ddram)
            && s_q.shiftOffset == ($past(execByte[`LCDCD_SH_RIGHT])
                                   ? $past(s_q.shiftOffset) - 7'h01
                                   : $past(s_q.shiftOffset) + 7'h01);
    endproperty
    a_dispShift: assert property (p_dispShift) // R07
        else $error("display shift moved cursor or memory, or went wrong way");

    // a byte offered while busy leaves address, memory and settings alone
    property p_refuse;
        busy && execValid
        |=> $stable(s_q.ddAddr) && $stable(s_q.ddram)
            && $stable(s_q.dispOn) && $stable(s_q.func);
    endproperty
    a_refuse: assert property (p_refuse) // R02
        else $error("byte taken while busy");

endmodule : lcdcd_core

/* hw/lcdcd_params.svh */
// constants of the character display command decoder: offsets, codes,
// field positions and busy times
// assumes a 40 MHz system clock and a byte-lane-0 register bus
// Behaviour
// R01: host sends commands to the command location
// R02: host polls busy bit before new command
// R03: command read gives busy and cursor address
// R04: 01 clears and homes, 02 homes; long delay
// R05: 04-07 set cursor direction and display shift
// R06: 08-0F set display, cursor, blink enables
// R07: 10-1C move cursor or display, data kept
// R08: 3C sets two-line forty-column function
// R09: 40-7F load glyph memory address
// R10: 80-FF load display address and cursor
// R11: data bytes stored and shown as glyphs
// R12: serial byte carries nibble, select, strobe
// R13: each nibble takes three strobe transfers
// R14: data write steps address, optionally shifts
// R15: host may wait fixed delays instead
`ifndef LCDCD_PARAMS_SVH
`define LCDCD_PARAMS_SVH

// register byte offsets
`define LCDCD_OFS_CMD      4'h0
`define LCDCD_OFS_DATA     4'h4
`define LCDCD_OFS_FLAGS    4'h8

// clock rate and completion times
`define LCDCD_CLK_MHZ      40
`define LCDCD_CLR_TIME_US  1650
`define LCDCD_CMD_TIME_US  40
`define LCDCD_CLR_CYCLES   (`LCDCD_CLR_TIME_US * `LCDCD_CLK_MHZ)
`define LCDCD_CMD_CYCLES   (`LCDCD_CMD_TIME_US * `LCDCD_CLK_MHZ)

// lowest code of each command group, then the default function set code
`define LCDCD_CODE_CLEAR   8'h01
`define LCDCD_CODE_HOME    8'h02
`define LCDCD_CODE_ENTRY   8'h04
`define LCDCD_CODE_DISP    8'h08
`define LCDCD_CODE_SHIFT   8'h10
`define LCDCD_CODE_FUNC    8'h20
`define LCDCD_CODE_CGADDR  8'h40
`define LCDCD_CODE_DDADDR  8'h80
`define LCDCD_CODE_FUNCDEF 8'h3C

// field positions inside command codes and the status read, blank character, display memory depth
`define LCDCD_ENT_INC      1
`define LCDCD_ENT_SHIFT    0
`define LCDCD_DC_DISP      2
`define LCDCD_DC_CUR       1
`define LCDCD_DC_BLINK     0
`define LCDCD_SH_DISP      3
`define LCDCD_SH_RIGHT     2
`define LCDCD_BUSY_BIT     7
`define LCDCD_BLANK        8'h20
`define LCDCD_DD_DEPTH     128

`endif

/* hw/lcdcd_pkg.sv */
// types of the character display command decoder
// assumes lcdcd_params.svh is included by the design file that uses them
package lcdcd_pkg;

    // wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } lcdcd_wbreq_t;

    // wishbone answer of the slave
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } lcdcd_wbrsp_t;

    // nibble pins behind the shift register
    typedef struct packed {
        logic [3:0] nibble;
        logic       registerSelectLine;
        logic       strobe;
    } lcdcd_pins_t;

    // display settings seen by the glyph renderer
    typedef struct packed {
        logic       dispOn;
        logic       cursorOn;
        logic       blinkOn;
        logic [6:0] cursorAddr;
        logic [6:0] shiftOffset;
    } lcdcd_view_t;

    typedef logic [16:0] lcdcd_busy_t;

    // whole state of the decoder
    typedef struct packed {
        logic                  ack;
        logic [31:0]           rdat;
        logic                  prevStrobe;
        logic                  nibPhase;
        logic [3:0]            hiNib;
        lcdcd_busy_t           busyCnt;
        logic [6:0]            ddAddr;
        logic [5:0]            cgAddr;
        logic                  selCg;
        logic                  incr;
        logic                  shiftEn;
        logic                  dispOn;
        logic                  cursorOn;
        logic                  blinkOn;
        logic [2:0]            func;
        logic [6:0]            shiftOffset;
        logic [7:0]            scanChar;
        logic [127:0][7:0]     ddram;
        logic [63:0][7:0]      cgram;
    } lcdcd_state_t;

endpackage : lcdcd_pkg
